// [shared/phc_defs.svh]
/*
 * Offsets, field positions, reset values and byte codes of the POS HDLC transmit channel.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef PHC_DEFS_SVH
`define PHC_DEFS_SVH

`define PHC_CFG_ADDR      8'h40
`define PHC_STAT_ADDR     8'h44
`define PHC_CFG_RESET     16'h004f
`define PHC_CFG_MASK      16'h01ff

`define PHC_B_PAYSCR      8
`define PHC_B_UFILL       7
`define PHC_B_FETCH       6
`define PHC_B_PERSIST     5
`define PHC_B_CORRUPT     4
`define PHC_B_FCS_HI      3
`define PHC_B_FCS_LO      2
`define PHC_B_HDRPASS     1
`define PHC_B_ENVSCR      0

`define PHC_FLAG          8'h7e
`define PHC_ESC           8'h7d
`define PHC_ESC_XOR       8'h20
`define PHC_ADDR_BYTE     8'hff
`define PHC_CTRL_BYTE     8'h03

`define PHC_CRC16_POLY    32'h0000_8408
`define PHC_CRC32_POLY    32'hedb8_8320
`define PHC_CRC16_INIT    32'h0000_ffff
`define PHC_CRC32_INIT    32'hffff_ffff
`define PHC_CRC16_LAST    2'h1
`define PHC_CRC32_LAST    2'h3

`endif

// [shared/phc_pkg.sv]
/*
 * Types shared by both ends of the transmit FIFO link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package phc_pkg;

   typedef enum logic [1:0] {
      PHC_FCS_NONE  = 2'b00,
      PHC_FCS_RSVD  = 2'b01,
      PHC_FCS_CRC16 = 2'b10,
      PHC_FCS_CRC32 = 2'b11
   } phc_fcs_t;

   typedef enum logic [2:0] {
      PHC_IDLE  = 3'b000,
      PHC_ADDR  = 3'b001,
      PHC_CTRL  = 3'b010,
      PHC_DATA  = 3'b011,
      PHC_FCS   = 3'b100,
      PHC_STUFF = 3'b101
   } phc_tx_st_t;

   typedef enum logic [1:0] {
      PHC_L_IDLE = 2'b00,
      PHC_L_CTRL = 2'b01,
      PHC_L_BODY = 2'b10
   } phc_lld_st_t;

endpackage : phc_pkg

// [shared/phc_if.sv]
/*
 * Byte-wide transmit FIFO link between the link-layer device and the HDLC transmitter.
 * Assumes both ends run on the same clock; valid/ready handshake, transfer when both high.
 */
`timescale 1ns/1ps
interface phc_if;
   logic [7:0] data;
   logic       sop;
   logic       eop;
   logic       valid;
   logic       ready;

   modport dev (
      input  data,
      input  sop,
      input  eop,
      input  valid,
      output ready
   );

   modport lld (
      output data,
      output sop,
      output eop,
      output valid,
      input  ready
   );
endinterface : phc_if

// [hw/phc_lld.sv]
/*
 * Link-layer end: takes user packets and writes them into the transmit FIFO link,
 * prepending Address and Control bytes when the transmitter passes headers through.
 * Assumes the same clock as the transmitter and a user source that holds data until taken.
 */
`timescale 1ns/1ps
`include "phc_defs.svh"
module phc_lld import phc_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        header_passthrough,
   input  wire logic [7:0]  usr_data,
   input  wire logic        usr_sop,
   input  wire logic        usr_eop,
   input  wire logic        usr_valid,
   output logic             usr_ready,
   phc_if.lld               fifo
);
   phc_lld_st_t st_q, st_d;
   logic [7:0]  data_q, data_d;
   logic        sop_q, sop_d;
   logic        eop_q, eop_d;
   logic        vld_q, vld_d;

   wire load     = ~vld_q | fifo.ready;
   wire usr_take = usr_valid & usr_ready;

   assign fifo.data  = data_q;
   assign fifo.sop   = sop_q;
   assign fifo.eop   = eop_q;
   assign fifo.valid = vld_q;

   always_comb begin
      st_d      = st_q;
      data_d    = data_q;
      sop_d     = sop_q;
      eop_d     = eop_q;
      vld_d     = vld_q & ~fifo.ready;
      usr_ready = 1'b0;
      unique case (st_q)
         PHC_L_IDLE: begin
            if (load && usr_valid && !usr_sop) begin
               // Stray bytes outside a packet are dropped
               usr_ready = 1'b1;
            end else if (load && usr_valid && header_passthrough) begin
               data_d = `PHC_ADDR_BYTE;
               sop_d  = 1'b1;
               eop_d  = 1'b0;
               vld_d  = 1'b1;
               st_d   = PHC_L_CTRL;
            end else if (load && usr_valid) begin
               usr_ready = 1'b1;
               data_d    = usr_data;
               sop_d     = 1'b1;
               eop_d     = usr_eop;
               vld_d     = 1'b1;
               st_d      = usr_eop ? PHC_L_IDLE : PHC_L_BODY;
            end
         end
         PHC_L_CTRL: begin
            if (load) begin
               data_d = `PHC_CTRL_BYTE;
               sop_d  = 1'b0;
               eop_d  = 1'b0;
               vld_d  = 1'b1;
               st_d   = PHC_L_BODY;
            end
         end
         PHC_L_BODY: begin
            usr_ready = load;
            if (usr_take) begin
               data_d = usr_data;
               sop_d  = 1'b0;
               eop_d  = usr_eop;
               vld_d  = 1'b1;
               st_d   = usr_eop ? PHC_L_IDLE : PHC_L_BODY;
            end
         end
         default: st_d = PHC_L_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q   <= PHC_L_IDLE;
         data_q <= 8'h00;
         sop_q  <= 1'b0;
         eop_q  <= 1'b0;
         vld_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         data_q <= data_d;
         sop_q  <= sop_d;
         eop_q  <= eop_d;
         vld_q  <= vld_d;
      end
   end
endmodule : phc_lld

// [hw/phc_tx.sv]
/*
 * Transmit HDLC controller of one POS channel: reads packets from the FIFO link, frames,
 * checks, scrambles and stuffs them into a byte stream; one configuration register.
 * Assumes a link-layer end on the same clock and a register master with one-cycle strobes.
 */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "phc_defs.svh"
module phc_tx import phc_pkg::*; (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic      [7:0]  line_data,
   output logic             line_frame,
   phc_if.dev               fifo
);
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b,
                                            input logic [31:0] poly);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ b[i]) ? ((r >> 1) ^ poly) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   // Payload scrambler, bit 0 first; returns {history, byte}
   function automatic logic [55:0] pay_scr(input logic [7:0] x, input logic [47:0] h);
      logic [47:0] s;
      logic [7:0]  y;
      s = h;
      y = 8'h00;
      for (int i = 0; i < 8; i++) begin
         y[i] = x[i] ^ s[26] ^ s[27] ^ s[47];
         s    = {s[46:0], y[i]};
      end
      return {s, y};
   endfunction : pay_scr

   function automatic logic [50:0] env_scr(input logic [7:0] x, input logic [42:0] h);
      logic [42:0] s;
      logic [7:0]  y;
      s = h;
      y = 8'h00;
      for (int i = 0; i < 8; i++) begin
         y[i] = x[i] ^ s[42];
         s    = {s[41:0], y[i]};
      end
      return {s, y};
   endfunction : env_scr

   phc_tx_st_t  st_q, st_d, ret_q, ret_d;
   logic [15:0] cfg_q, cfg_d;
   logic [15:0] rdata_q;
   logic [7:0]  esc_q, esc_d;
   logic [31:0] crc_q, crc_d;
   logic [1:0]  idx_q;
   logic [47:0] pscr_q;
   logic [42:0] escr_q;
   logic [7:0]  line_q;
   logic        frame_q;
   logic [7:0]  frames_q;
   logic [6:0]  aborts_q;
   logic        f_payscr_q, f_ufill_q, f_hdrgen_q, f_corrupt_q, f_persist_q;
   phc_fcs_t    f_fcs_q;
   logic [7:0]  raw, cont, lb;
   phc_tx_st_t  nxt;

   wire       cfg_fetch   = cfg_q[`PHC_B_FETCH];
   wire [1:0] cfg_fcs     = cfg_q[`PHC_B_FCS_HI:`PHC_B_FCS_LO];
   wire       cfg_fcs_on  = (cfg_fcs == PHC_FCS_CRC16) | (cfg_fcs == PHC_FCS_CRC32);
   wire       f_fcs_on    = (f_fcs_q == PHC_FCS_CRC16) | (f_fcs_q == PHC_FCS_CRC32);
   wire       is_data     = (st_q == PHC_DATA);
   wire       start       = (st_q == PHC_IDLE) & cfg_fetch & fifo.valid & fifo.sop;
   wire       drop        = (st_q == PHC_IDLE) & cfg_fetch & fifo.valid & ~fifo.sop;
   wire       take        = fifo.valid & fifo.ready;
   wire       underflow   = is_data & ~fifo.valid;
   wire [1:0] fcs_last_ix = (f_fcs_q == PHC_FCS_CRC32) ? `PHC_CRC32_LAST : `PHC_CRC16_LAST;
   wire       fcs_last    = (st_q == PHC_FCS) & (idx_q == fcs_last_ix);
   wire [31:0] poly       = (f_fcs_q == PHC_FCS_CRC32) ? `PHC_CRC32_POLY : `PHC_CRC16_POLY;
   wire       hdr_byte    = (st_q == PHC_ADDR) | (st_q == PHC_CTRL);
   wire       adv         = hdr_byte | (st_q == PHC_FCS) | (is_data & take);
   wire [55:0] pscr_res   = pay_scr(fifo.data, pscr_q);
   wire       need_esc    = (cont == `PHC_FLAG) | (cont == `PHC_ESC);
   wire       via_esc     = adv & need_esc;
   wire [50:0] escr_res   = env_scr(lb, escr_q);
   wire       env_on      = cfg_q[`PHC_B_ENVSCR];
   wire       hw_clr      = fcs_last & f_corrupt_q & ~f_persist_q;
   wire       wr_cfg      = reg_wr & (reg_addr == `PHC_CFG_ADDR);
   wire [15:0] stat       = {frame_q, aborts_q, frames_q};
   wire [15:0] rd_mux     = (reg_addr == `PHC_CFG_ADDR)  ? cfg_q :
                            (reg_addr == `PHC_STAT_ADDR) ? stat  : 16'h0000;

   assign fifo.ready = is_data | drop;
   assign reg_rdata  = rdata_q;
   assign line_data  = line_q;
   assign line_frame = frame_q;

   always_comb begin
      unique case (st_q)
         PHC_ADDR: raw = `PHC_ADDR_BYTE;
         PHC_CTRL: raw = `PHC_CTRL_BYTE;
         PHC_FCS:  raw = ~crc_q[7:0] ^ {8{f_corrupt_q}};
         default:  raw = fifo.data;
      endcase
      cont = (is_data && f_payscr_q) ? pscr_res[7:0] : raw;
   end

   always_comb begin
      nxt   = st_q;
      ret_d = ret_q;
      esc_d = esc_q;
      lb    = cont;
      unique case (st_q)
         PHC_IDLE:  nxt = start ? (cfg_q[`PHC_B_HDRPASS] ? PHC_DATA : PHC_ADDR) : PHC_IDLE;
         PHC_ADDR:  nxt = PHC_CTRL;
         PHC_CTRL:  nxt = PHC_DATA;
         PHC_DATA:  nxt = (take && fifo.eop) ? (f_fcs_on ? PHC_FCS : PHC_IDLE) : PHC_DATA;
         PHC_FCS:   nxt = fcs_last ? PHC_IDLE : PHC_FCS;
         PHC_STUFF: nxt = ret_q;
         default:   nxt = PHC_IDLE;
      endcase
      st_d = nxt;
      if (st_q == PHC_IDLE) begin
         lb = `PHC_FLAG;
      end else if (st_q == PHC_STUFF) begin
         lb = esc_q;
      end else if (underflow) begin
         lb    = `PHC_ESC;
         st_d  = PHC_STUFF;
         esc_d = f_ufill_q ? `PHC_ESC : `PHC_FLAG;
         ret_d = f_ufill_q ? PHC_DATA : PHC_IDLE;
      end else if (via_esc) begin
         lb    = `PHC_ESC;
         st_d  = PHC_STUFF;
         esc_d = cont ^ `PHC_ESC_XOR;
         ret_d = nxt;
      end
   end

   always_comb begin
      cfg_d = cfg_q;
      if (wr_cfg) begin
         cfg_d = reg_wdata & `PHC_CFG_MASK;
      end
      if (hw_clr && !(wr_cfg && reg_wdata[`PHC_B_CORRUPT])) begin
         cfg_d[`PHC_B_CORRUPT] = 1'b0;
      end
      crc_d = crc_q;
      if (start) begin
         crc_d = (cfg_fcs == PHC_FCS_CRC32) ? `PHC_CRC32_INIT : `PHC_CRC16_INIT;
      end else if (st_q == PHC_FCS) begin
         crc_d = crc_q >> 8;
      end else if (adv) begin
         // CRC over unscrambled header and data
         crc_d = crc_step(crc_q, raw, poly);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_q   <= `PHC_CFG_RESET;
         rdata_q <= 16'h0000;
         st_q    <= PHC_IDLE;
         ret_q   <= PHC_IDLE;
         esc_q   <= 8'h00;
         crc_q   <= 32'h0000_0000;
         line_q  <= 8'h00;
         frame_q <= 1'b0;
      end else begin
         cfg_q   <= cfg_d;
         rdata_q <= reg_rd ? rd_mux : 16'h0000;
         st_q    <= st_d;
         ret_q   <= ret_d;
         esc_q   <= esc_d;
         crc_q   <= crc_d;
         line_q  <= env_on ? escr_res[7:0] : lb;
         frame_q <= (st_q != PHC_IDLE);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idx_q  <= 2'h0;
         pscr_q <= 48'h0;
         escr_q <= 43'h0;
      end else begin
         idx_q  <= start ? 2'h0 : ((st_q == PHC_FCS) ? idx_q + 2'h1 : idx_q);
         pscr_q <= (is_data && take && f_payscr_q) ? pscr_res[55:8] : pscr_q;
         escr_q <= env_on ? escr_res[50:8] : escr_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         f_payscr_q  <= 1'b0;
         f_ufill_q   <= 1'b0;
         f_hdrgen_q  <= 1'b0;
         f_corrupt_q <= 1'b0;
         f_persist_q <= 1'b0;
         f_fcs_q     <= PHC_FCS_NONE;
      end else if (start) begin
         f_payscr_q  <= cfg_q[`PHC_B_PAYSCR];
         f_ufill_q   <= cfg_q[`PHC_B_UFILL];
         f_hdrgen_q  <= ~cfg_q[`PHC_B_HDRPASS];
         f_corrupt_q <= cfg_q[`PHC_B_CORRUPT] & cfg_fcs_on;
         f_persist_q <= cfg_q[`PHC_B_PERSIST];
         f_fcs_q     <= phc_fcs_t'(cfg_fcs);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frames_q <= 8'h00;
         aborts_q <= 7'h00;
      end else begin
         frames_q <= (is_data && take && fifo.eop) ? frames_q + 8'h01 : frames_q;
         aborts_q <= (underflow && !f_ufill_q) ? aborts_q + 7'h01 : aborts_q;
      end
   end
endmodule : phc_tx

// [tb/phc_link_props.sv]
/*
 * Checker of the transmit FIFO link between the link-layer end and the transmitter.
 * Assumes the bench instantiates it beside the link and stuffing stays on raw bytes.
 */
`timescale 1ns/1ps
module phc_link_props (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [7:0] data,
   input wire logic       sop,
   input wire logic       eop,
   input wire logic       valid,
   input wire logic       ready
);
   logic in_pkt_q;
   logic in_pkt_d;
   wire  taken = valid & ready;

   assign in_pkt_d = taken ? !eop : in_pkt_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) in_pkt_q <= 1'b0;
      else in_pkt_q <= in_pkt_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_wait;
      valid && !ready;
   endsequence
   sequence s_new_sop;
      $rose(valid) && sop;
   endsequence
   sequence s_taken_eop;
      valid && ready && eop;
   endsequence
   sequence s_taken_esc;
      valid && ready && !eop && (data == 8'h7e || data == 8'h7d);
   endsequence

   a_valid_held: assert property (s_wait |=> valid)
      else $error("link byte withdrawn before taken");
   a_bytes_stable: assert property (s_wait |=> $stable(data) && $stable(sop) && $stable(eop))
      else $error("link byte changed before taken");
   a_pkt_order: assert property (valid |-> sop == !in_pkt_q)
      else $error("packet start marker out of order");
   a_sop_not_first: assert property (s_new_sop |-> !ready)
      else $error("packet start taken in idle cycle");
   a_sop_served: assert property (s_new_sop |-> ##[1:1000] (valid && ready))
      else $error("packet start never taken");
   a_eop_gap: assert property (s_taken_eop |=> !(valid && ready))
      else $error("byte taken right after packet end");
   a_esc_stall: assert property (s_taken_esc |=> !ready ##1 ready)
      else $error("escape byte not stuffed for one cycle");
   a_sop_past: assert property (valid && ready && sop |-> $past(valid && sop))
      else $error("packet start consumed without wait");
endmodule : phc_link_props

// [tb/pos_hdlc_tx_config_test.sv]
/*
 * Bench: both ends joined by the link; register port driven, line stream judged.
 * Assumes package, header, interface and design files are compiled before it.
 */
`timescale 1ns/1ps
`include "phc_defs.svh"
module pos_hdlc_tx_config_test import phc_pkg::*; ;
   logic        clk;
   logic        rstn;
   logic        reg_wr;
   logic        reg_rd;
   logic        hp;
   logic        busy;
   logic        usr_sop;
   logic        usr_eop;
   logic        usr_valid;
   logic        usr_ready;
   logic        line_frame;
   logic [7:0]  reg_addr;
   logic [7:0]  usr_data;
   logic [7:0]  line_data;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [15:0] rv;
   logic [7:0]  cap[$];
   logic [7:0]  pl[5] = '{8'h7d, 8'h7e, 8'h11, 8'h22, 8'h33};
   int          miscompares = 0;
   int          tests_run = 0;

   phc_if link ();
   phc_tx phc_tx_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_data(line_data),
      .line_frame(line_frame), .fifo(link.dev));
   phc_lld phc_lld_i (.clk(clk), .rstn(rstn), .header_passthrough(hp), .usr_data(usr_data),
      .usr_sop(usr_sop), .usr_eop(usr_eop), .usr_valid(usr_valid), .usr_ready(usr_ready),
      .fifo(link.lld));
   phc_link_props phc_link_props_i (.clk(clk), .rstn(rstn), .data(link.data), .sop(link.sop),
      .eop(link.eop), .valid(link.valid), .ready(link.ready));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) if (line_frame === 1'b1) cap.push_back(line_data);

   task automatic results();
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   task automatic tmo();
      miscompares++;
      results();
   endtask : tmo

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      rv = reg_rdata;
   endtask : rd

   function automatic logic [31:0] crc(input logic [7:0] q[$], input logic [1:0] fs);
      logic [31:0] r;
      logic [31:0] p;
      r = (fs == 2'b11) ? `PHC_CRC32_INIT : `PHC_CRC16_INIT;
      p = (fs == 2'b11) ? `PHC_CRC32_POLY : `PHC_CRC16_POLY;
      foreach (q[i]) begin
         r ^= {24'h0, q[i]};
         for (int b = 0; b < 8; b++) r = r[0] ? ((r >> 1) ^ p) : (r >> 1);
      end
      return ~r;
   endfunction : crc

   // Packet source; underflow by dropping valid after second byte
   task automatic send(input int stall);
      int n;
      for (int i = 0; i < 5; i++) begin
         usr_data  <= pl[i];
         usr_sop   <= (i == 0);
         usr_eop   <= (i == 4);
         usr_valid <= 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (usr_ready !== 1'b1 && n < 300);
         if (n >= 300) tmo();
         if (i == 1 && stall > 0) begin
            usr_valid <= 1'b0;
            usr_data  <= ~pl[i];
            repeat (stall) @(posedge clk);
         end
      end
      usr_valid <= 1'b0;
      busy = 1'b0;
   endtask : send

   task automatic frame(input logic [15:0] v, input logic inv, input int stall);
      logic [7:0]  e[$];
      logic [7:0]  d[$];
      logic [31:0] c;
      logic [47:0] h;
      logic [7:0]  y;
      int          n;
      wr(`PHC_CFG_ADDR, v);
      hp <= v[1];
      cap = {};
      busy = 1'b1;
      fork
         send(stall);
      join_none
      if (!v[6]) begin
         repeat (30) begin
            @(posedge clk);
            cmp({line_frame, line_data}, 9'h07e);
         end
         wr(`PHC_CFG_ADDR, v | 16'h0040);
      end
      n = 0;
      while ((line_frame !== 1'b0 || cap.size() == 0 || busy) && n < 500) begin
         @(posedge clk);
         n++;
      end
      if (n >= 500) tmo();
      repeat (3) @(posedge clk);
      for (int i = 0; i < cap.size(); i++) begin
         if (cap[i] == `PHC_ESC) begin
            if (cap[i+1] != `PHC_ESC) d.push_back(cap[i+1] ^ `PHC_ESC_XOR);
            i++;
         end else if (cap[i] != `PHC_FLAG) d.push_back(cap[i]);
      end
      if (!v[7] && stall > 0) return;
      e = {`PHC_ADDR_BYTE, `PHC_CTRL_BYTE, pl[0], pl[1], pl[2], pl[3], pl[4]};
      c = crc(e, v[3:2]) ^ {32{inv}};
      // Payload scrambler model, history zero from reset
      if (v[8]) begin
         h = 48'h0;
         for (int i = 2; i < 7; i++) begin
            y = e[i];
            for (int b = 0; b < 8; b++) begin
               y[b] = y[b] ^ h[26] ^ h[27] ^ h[47];
               h    = {h[46:0], y[b]};
            end
            e[i] = y;
         end
      end
      for (int i = 0; i < (v[3:2] == 2'b11 ? 4 : v[3:2] == 2'b10 ? 2 : 0); i++)
         e.push_back(c[8*i +: 8]);
      cmp(d.size(), e.size());
      foreach (e[i]) cmp(d[i], e[i]);
   endtask : frame

   task automatic regs();
      int k;
      rd(`PHC_CFG_ADDR);
      cmp(rv, `PHC_CFG_RESET);
      rd(`PHC_STAT_ADDR);
      cmp(rv, 16'h0000);
      k = 0;
      repeat (16) begin
         @(posedge clk);
         if (line_data !== `PHC_FLAG) k++;
      end
      cmp(k != 0, 1'b1);
      wr(`PHC_CFG_ADDR, 16'hffff);
      rd(`PHC_CFG_ADDR);
      cmp(rv, `PHC_CFG_MASK);
      wr(8'h20, 16'h0000);
      rd(8'h20);
      cmp(rv, 16'h0000);
      rd(`PHC_CFG_ADDR);
      cmp(rv, `PHC_CFG_MASK);
   endtask : regs

   task automatic fcs_modes();
      for (int f = 0; f < 4; f++)
         for (int h = 0; h < 2; h++)
            frame(16'h0060 | 16'(f << 2) | 16'(h << 1), 1'b0, 0);
   endtask : fcs_modes

   task automatic corrupt();
      frame(16'h0058, 1'b1, 0);
      rd(`PHC_CFG_ADDR);
      cmp(rv, 16'h0048);
      frame(16'h007c, 1'b1, 0);
      frame(16'h007c, 1'b1, 0);
      rd(`PHC_CFG_ADDR);
      cmp(rv, 16'h007c);
      frame(16'h0068, 1'b0, 0);
   endtask : corrupt

   task automatic underflow();
      frame(16'h0048, 1'b0, 6);
      rd(`PHC_STAT_ADDR);
      cmp(rv[14:8], 7'h01);
      cmp(rv[7:0], 8'h0e);
      frame(16'h00c8, 1'b0, 6);
   endtask : underflow

   initial begin
      rstn      = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
      hp        = 1'b1;
      busy      = 1'b0;
      usr_data  = 8'h00;
      usr_sop   = 1'b0;
      usr_eop   = 1'b0;
      usr_valid = 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      regs();
      fcs_modes();
      corrupt();
      frame(16'h0148, 1'b0, 0);
      frame(16'h0008, 1'b0, 0);
      underflow();
      results();
   end
endmodule : pos_hdlc_tx_config_test
